// ==== hdl/cms_pkg.sv ====
package cms_pkg;
  // register byte offsets
  localparam logic [5:0] OFF_CMD = 6'h00;
  localparam logic [5:0] OFF_PC = 6'h04;
  localparam logic [5:0] OFF_SP = 6'h08;
  localparam logic [5:0] OFF_PSW = 6'h0C;
  localparam logic [5:0] OFF_RPS = 6'h10;
  localparam logic [5:0] OFF_PADDR = 6'h14;
  localparam logic [5:0] OFF_PDATA = 6'h18;
  localparam logic [5:0] OFF_DADDR = 6'h1C;
  localparam logic [5:0] OFF_DDATA = 6'h20;
  localparam logic [5:0] OFF_FETCH = 6'h24;
  localparam logic [5:0] OFF_STATUS = 6'h28;
  // status word bit positions
  localparam int PSW_C = 0;
  localparam int PSW_Z = 1;
  localparam int PSW_I = 2;
  localparam int PSW_H = 3;
  localparam int PSW_B = 4;
  localparam int PSW_G = 5;
  localparam int PSW_V = 6;
  localparam int PSW_N = 7;
  // reset values
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [1:0] RPS_RST = 2'h0;
  localparam logic [15:0] PC_RST = 16'h0000;
  // program memory landmarks, plus the stack page of user ram
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TABLE0 = 16'hFFDE;
  localparam logic [15:0] VEC_INT_TOP = 16'hFFFE;
  localparam logic [7:0] PAGE_CALL_PAGE = 8'hFF;
  localparam logic STACK_PAGE = 1'b1;
  // engine commands, written to cmd[3:0]
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_RSTV = 4'h1;
  localparam logic [3:0] CMD_CALL = 4'h2;
  localparam logic [3:0] CMD_PAGE_CALL = 4'h3;
  localparam logic [3:0] CMD_TABLE_CALL = 4'h4;
  localparam logic [3:0] CMD_INT = 4'h5;
  localparam logic [3:0] CMD_RET = 4'h6;
  localparam logic [3:0] CMD_INTERRUPT_RETURN = 4'h7;
  localparam logic [3:0] CMD_SET_DIRECT_PAGE_FLAG = 4'h8;
  localparam logic [3:0] CMD_CLEAR_DIRECT_PAGE_FLAG = 4'h9;
endpackage

// ==== hdl/cms_stack_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module cms_stack_unit (
  input wire logic clk, // core clock
  input wire logic ld, // software load
  input wire logic [7:0] ld_val, // value loaded
  input wire logic push, // one byte saved this cycle
  input wire logic pop, // one byte restored this cycle
  output logic [7:0] sp, // stack_pointer
  output logic [7:0] wr_addr, // save slot
  output logic [7:0] rd_addr // restore slot
);
  // no reset on purpose: software must set the pointer before first use
  always_ff @(posedge clk) begin
    if (ld) begin
      sp <= ld_val;
    end else if (push) begin
      sp <= sp - 8'h01;
    end else if (pop) begin
      sp <= sp + 8'h01;
    end
  end

  assign wr_addr = sp;
  assign rd_addr = sp + 8'h01;
endmodule
`default_nettype wire

// ==== hdl/cms_page_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module cms_page_decode #(
  parameter int RAM_BYTES = 512
) (
  input wire logic g_flag, // direct page flag
  input wire logic [1:0] page_sel, // ram_page_select field
  input wire logic [7:0] direct_addr, // direct operand
  output logic [9:0] ram_addr, // full user ram address
  output logic in_range // address hits real ram
);
  logic [1:0] page;

  // flag clear forces page 0 whatever the page field holds
  assign page = g_flag ? page_sel : 2'h0;
  assign ram_addr = {page, direct_addr};
  assign in_range = 32'(ram_addr) < RAM_BYTES;
endmodule
`default_nettype wire

// ==== hdl/cms_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cms_top #(
  parameter int PROG_BYTES = 16384,
  parameter int RAM_BYTES = 512
) (
  input wire logic clk, // core clock, 20 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [5:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest // stall
);
  localparam int PA_W = $clog2(PROG_BYTES);
  localparam int RA_W = $clog2(RAM_BYTES);

  typedef enum logic [1:0] {B_IDLE, B_RUN, B_ACK} cms_bus_t;
  typedef enum logic [3:0] {
    E_IDLE, E_VLO, E_VHI, E_PUSH_H, E_PUSH_L, E_PUSH_P,
    E_POP_P, E_POP_L, E_POP_H, E_DONE
  } cms_eng_t;

  logic [7:0] prog_mem [PROG_BYTES];
  logic [7:0] data_mem [RAM_BYTES];

  cms_bus_t bus_state;
  cms_eng_t eng_state;
  logic [15:0] pc;
  logic [7:0] psw;
  logic [1:0] rps;
  logic [15:0] prog_addr;
  logic [7:0] direct_addr;
  logic [3:0] op;
  logic [3:0] op_idx;
  logic [15:0] vec_addr;
  logic [15:0] target;
  logic [7:0] sp;
  logic [7:0] stk_wr;
  logic [7:0] stk_rd;
  logic [9:0] dec_addr;
  logic dec_ok;

  logic acc;
  logic acc_wr;
  logic acc_rd;
  logic eng_start;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic stk_push;
  logic stk_pop;
  logic [7:0] stk_wdata;
  logic [7:0] pop_byte;
  logic eng_pc_ld;
  logic [15:0] eng_pc_val;
  logic [7:0] vec_lo;
  logic [7:0] vec_hi;
  logic [7:0] fetch_byte;
  logic [7:0] prog_byte;
  logic [7:0] direct_byte;
  logic [31:0] next_readdata;

  localparam logic STACK_PAGE_BIT = cms_pkg::STACK_PAGE;

  // the 64K space folds onto the physical store, so vectors alias the top of it
  function automatic logic [7:0] prog_rd(input logic [15:0] a);
    prog_rd = prog_mem[a[PA_W-1:0]];
  endfunction

  function automatic logic [RA_W-1:0] stack_idx(input logic [7:0] s);
    stack_idx = RA_W'({STACK_PAGE_BIT, s});
  endfunction

  // bus accepts nothing while the engine runs, so ram and pc have one writer at a time
  assign acc = (bus_state == B_IDLE) && (avs_read || avs_write) && (eng_state == E_IDLE);
  assign acc_wr = acc && avs_write;
  assign acc_rd = acc && avs_read;
  assign eng_start = acc_wr && (avs_address == cms_pkg::OFF_CMD) && avs_byteenable[0];
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wval = avs_writedata & wmask;

  cms_stack_unit u_stack (
    .clk(clk),
    .ld(acc_wr && (avs_address == cms_pkg::OFF_SP) && avs_byteenable[0]),
    .ld_val(avs_writedata[7:0]),
    .push(stk_push),
    .pop(stk_pop),
    .sp(sp),
    .wr_addr(stk_wr),
    .rd_addr(stk_rd)
  );

  cms_page_decode #(.RAM_BYTES(RAM_BYTES)) u_decode (
    .g_flag(psw[cms_pkg::PSW_G]),
    .page_sel(rps),
    .direct_addr(direct_addr),
    .ram_addr(dec_addr),
    .in_range(dec_ok)
  );

  assign pop_byte = data_mem[stack_idx(stk_rd)];
  assign vec_lo = prog_rd(vec_addr);
  assign vec_hi = prog_rd(vec_addr + 16'h0001);
  assign fetch_byte = prog_rd(pc);
  assign prog_byte = prog_rd(prog_addr);
  // page 2 lies past the real ram, so it reads as zero instead of aliasing
  assign direct_byte = dec_ok ? data_mem[dec_addr[RA_W-1:0]] : 8'h00;

  // engine side effects per state
  always_comb begin
    stk_push = 1'b0;
    stk_pop = 1'b0;
    stk_wdata = 8'h00;
    eng_pc_ld = 1'b0;
    eng_pc_val = target;
    case (eng_state)
      E_VHI: begin
        eng_pc_ld = (op == cms_pkg::CMD_RSTV);
        eng_pc_val = {vec_hi, vec_lo};
      end
      E_PUSH_H: begin
        stk_push = 1'b1;
        stk_wdata = pc[15:8];
      end
      E_PUSH_L: begin
        stk_push = 1'b1;
        stk_wdata = pc[7:0];
        eng_pc_ld = (op != cms_pkg::CMD_INT);
      end
      E_PUSH_P: begin
        stk_push = 1'b1;
        stk_wdata = psw;
        eng_pc_ld = 1'b1;
      end
      E_POP_P: begin
        stk_pop = 1'b1;
      end
      E_POP_L: begin
        stk_pop = 1'b1;
        eng_pc_ld = 1'b1;
        eng_pc_val = {pc[15:8], pop_byte};
      end
      E_POP_H: begin
        stk_pop = 1'b1;
        eng_pc_ld = 1'b1;
        eng_pc_val = {pop_byte, pc[7:0]};
      end
      default: begin
        stk_push = 1'b0;
      end
    endcase
  end

  // sequencer; it runs the reset vector load by itself on leaving reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eng_state <= E_VLO;
      op <= cms_pkg::CMD_RSTV;
      op_idx <= 4'h0;
      vec_addr <= cms_pkg::VEC_RESET;
      target <= 16'h0000;
    end else begin
      case (eng_state)
        E_IDLE: begin
          if (eng_start) begin
            op <= avs_writedata[3:0];
            op_idx <= avs_writedata[7:4];
            case (avs_writedata[3:0])
              cms_pkg::CMD_RSTV: begin
                vec_addr <= cms_pkg::VEC_RESET;
                eng_state <= E_VLO;
              end
              cms_pkg::CMD_CALL: begin
                target <= avs_writedata[31:16];
                eng_state <= E_PUSH_H;
              end
              cms_pkg::CMD_PAGE_CALL: begin
                target <= {cms_pkg::PAGE_CALL_PAGE, avs_writedata[15:8]};
                eng_state <= E_PUSH_H;
              end
              cms_pkg::CMD_TABLE_CALL: begin
                vec_addr <= cms_pkg::VEC_TABLE0 - {11'h000, avs_writedata[7:4], 1'b0};
                eng_state <= E_VLO;
              end
              cms_pkg::CMD_INT: begin
                vec_addr <= cms_pkg::VEC_INT_TOP - {11'h000, avs_writedata[7:4], 1'b0};
                eng_state <= E_VLO;
              end
              cms_pkg::CMD_RET: eng_state <= E_POP_L;
              cms_pkg::CMD_INTERRUPT_RETURN: eng_state <= E_POP_P;
              default: eng_state <= E_DONE;
            endcase
          end
        end
        E_VLO: eng_state <= E_VHI;
        E_VHI: begin
          target <= {vec_hi, vec_lo};
          eng_state <= (op == cms_pkg::CMD_RSTV) ? E_DONE : E_PUSH_H;
        end
        E_PUSH_H: eng_state <= E_PUSH_L;
        E_PUSH_L: eng_state <= (op == cms_pkg::CMD_INT) ? E_PUSH_P : E_DONE;
        E_PUSH_P: eng_state <= E_DONE;
        E_POP_P: eng_state <= E_POP_L;
        E_POP_L: eng_state <= E_POP_H;
        E_POP_H: eng_state <= E_DONE;
        E_DONE: eng_state <= E_IDLE;
        default: eng_state <= E_IDLE;
      endcase
    end
  end

  // program counter: engine loads, software loads, fetch increments
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= cms_pkg::PC_RST;
    end else if (eng_pc_ld) begin
      // engine load wins; the bus is refused while it runs anyway
      pc <= eng_pc_val;
    end else if (acc_wr && (avs_address == cms_pkg::OFF_PC)) begin
      pc <= (pc & ~wmask[15:0]) | wval[15:0];
    end else if (acc_rd && (avs_address == cms_pkg::OFF_FETCH)) begin
      pc <= pc + 16'h0001;
    end
  end

  // status word: software, direct page flag commands, interrupt entry and exit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      psw <= cms_pkg::PSW_RST;
    end else if (eng_state == E_PUSH_P) begin
      // saved copy keeps the old enable; only the live word loses it
      psw[cms_pkg::PSW_I] <= 1'b0;
    end else if (eng_state == E_POP_P) begin
      psw <= pop_byte;
    end else if (eng_start && (avs_writedata[3:0] == cms_pkg::CMD_SET_DIRECT_PAGE_FLAG)) begin
      psw[cms_pkg::PSW_G] <= 1'b1;
    end else if (eng_start && (avs_writedata[3:0] == cms_pkg::CMD_CLEAR_DIRECT_PAGE_FLAG)) begin
      psw[cms_pkg::PSW_G] <= 1'b0;
    end else if (acc_wr && (avs_address == cms_pkg::OFF_PSW) && avs_byteenable[0]) begin
      psw <= avs_writedata[7:0];
    end
  end

  // page field only steers direct addressing while the flag is set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rps <= cms_pkg::RPS_RST;
    end else if (acc_wr && (avs_address == cms_pkg::OFF_RPS) && avs_byteenable[0]) begin
      rps <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_addr <= 16'h0000;
      direct_addr <= 8'h00;
    end else if (acc_wr) begin
      if (avs_address == cms_pkg::OFF_PADDR) begin
        prog_addr <= (prog_addr & ~wmask[15:0]) | wval[15:0];
      end
      if ((avs_address == cms_pkg::OFF_DADDR) && avs_byteenable[0]) begin
        direct_addr <= avs_writedata[7:0];
      end
    end
  end

  // program store is loaded over the bus only; the cpu never writes it
  always_ff @(posedge clk) begin
    if (acc_wr && (avs_address == cms_pkg::OFF_PDATA) && avs_byteenable[0]) begin
      prog_mem[prog_addr[PA_W-1:0]] <= avs_writedata[7:0];
    end
  end

  // user ram and stack share one array; stack is the upper half
  always_ff @(posedge clk) begin
    if (stk_push) begin
      // push wins: no bus write is taken while the engine owns the ram
      data_mem[stack_idx(stk_wr)] <= stk_wdata;
    end else if (acc_wr && (avs_address == cms_pkg::OFF_DDATA) && avs_byteenable[0] && dec_ok) begin
      data_mem[dec_addr[RA_W-1:0]] <= avs_writedata[7:0];
    end
  end

  always_comb begin
    next_readdata = 32'h00000000;
    case (avs_address)
      cms_pkg::OFF_CMD: next_readdata = {24'h000000, op_idx, op};
      cms_pkg::OFF_PC: next_readdata = {16'h0000, pc};
      cms_pkg::OFF_SP: next_readdata = {24'h000000, sp};
      cms_pkg::OFF_PSW: next_readdata = {24'h000000, psw};
      cms_pkg::OFF_RPS: next_readdata = {30'h0, rps};
      cms_pkg::OFF_PADDR: next_readdata = {16'h0000, prog_addr};
      cms_pkg::OFF_PDATA: next_readdata = {24'h000000, prog_byte};
      cms_pkg::OFF_DADDR: next_readdata = {24'h000000, direct_addr};
      cms_pkg::OFF_DDATA: next_readdata = {24'h000000, direct_byte};
      cms_pkg::OFF_FETCH: next_readdata = {24'h000000, fetch_byte};
      cms_pkg::OFF_STATUS: next_readdata = {22'h0, dec_addr[9:8], 6'h00, 1'b0, dec_ok};
      default: next_readdata = 32'h00000000;
    endcase
  end

  // one wait state for plain accesses; commands hold the bus until done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= B_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      case (bus_state)
        B_IDLE: begin
          if (eng_start) begin
            bus_state <= B_RUN;
          end else if (acc) begin
            bus_state <= B_ACK;
            avs_waitrequest <= 1'b0;
            if (avs_read) begin
              avs_readdata <= next_readdata;
            end
          end
        end
        B_RUN: begin
          if (eng_state == E_DONE) begin
            bus_state <= B_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        B_ACK: begin
          bus_state <= B_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state <= B_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== test/cms_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module cms_top_sva (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic [5:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest // stall
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [1:0] rps_seen;
  // last page value written over the bus, compared against readback
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rps_seen <= cms_pkg::RPS_RST;
    end else if (avs_write && !avs_waitrequest && avs_address == cms_pkg::OFF_RPS && avs_byteenable[0]) begin
      rps_seen <= avs_writedata[1:0];
    end
  end
  chk_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_answer_needs_request: assert property (!avs_waitrequest |-> (avs_read || avs_write))
    else $error("answer without a request");
  chk_answer_bounded: assert property ((avs_read || avs_write) |-> ##[0:12] !avs_waitrequest)
    else $error("request not answered in time");
  chk_readdata_holds: assert property ((avs_readdata != $past(avs_readdata)) |-> (!avs_waitrequest && avs_read))
    else $error("read data changed outside a read answer");
  chk_unmapped_zero: assert property ((avs_read && !avs_waitrequest && avs_address == 6'h3C)
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_page_width: assert property ((avs_read && !avs_waitrequest && avs_address == cms_pkg::OFF_RPS)
    |-> avs_readdata == {30'h0, rps_seen})
    else $error("page select readback wrong");
  chk_sp_width: assert property ((avs_read && !avs_waitrequest && avs_address == cms_pkg::OFF_SP)
    |-> avs_readdata[31:8] == 24'h0)
    else $error("stack pointer wider than eight bits");
  chk_pc_width: assert property ((avs_read && !avs_waitrequest && avs_address == cms_pkg::OFF_PC)
    |-> avs_readdata[31:16] == 16'h0)
    else $error("program counter wider than sixteen bits");
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] rv;
  int failures = 0;
  int num_checks = 0;
  cms_top u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // request held until the edge that samples waitrequest low
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    @(posedge clk);
    // only the watchdog ends a wait that never gets an answer
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // idle edge so the next request is not assigned in the same step
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    xfer(1'b0, a, d);
  endtask
  task automatic chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b1, a, 32'h0);
    num_checks++;
    if ((rv & m) !== e) begin
      failures++;
      $display("mismatch at %0t: offset %h got %h expected %h", $time, a, rv, e);
    end
  endtask
  task automatic pb(input logic [15:0] pa, input logic [7:0] b);
    wr(cms_pkg::OFF_PADDR, {16'h0, pa});
    wr(cms_pkg::OFF_PDATA, {24'h0, b});
  endtask
  task automatic t_vector();
    chk(cms_pkg::OFF_RPS, 32'hFFFFFFFF, 32'h0);
    chk(cms_pkg::OFF_PSW, 32'hFF, {24'h0, cms_pkg::PSW_RST});
    pb(16'hFFFE, 8'h34);
    pb(16'hFFFF, 8'h12);
    wr(cms_pkg::OFF_CMD, {28'h0, cms_pkg::CMD_RSTV});
    chk(cms_pkg::OFF_PC, 32'hFFFF, 32'h1234);
    wr(cms_pkg::OFF_PADDR, 32'h3FFE);
    chk(cms_pkg::OFF_PDATA, 32'hFF, 32'h34);
  endtask
  task automatic t_fetch();
    pb(16'hFFFF, 8'h5A);
    pb(16'hFF50, 8'hC3);
    wr(cms_pkg::OFF_PC, 32'hFFFF);
    chk(cms_pkg::OFF_FETCH, 32'hFF, 32'h5A);
    chk(cms_pkg::OFF_PC, 32'hFFFF, 32'h0);
    wr(cms_pkg::OFF_PC, 32'hFF50);
    chk(cms_pkg::OFF_FETCH, 32'hFF, 32'hC3);
    chk(cms_pkg::OFF_PC, 32'hFFFF, 32'hFF51);
  endtask
  task automatic t_call();
    wr(cms_pkg::OFF_SP, 32'hFF);
    wr(cms_pkg::OFF_PC, 32'h0456);
    wr(cms_pkg::OFF_CMD, {16'h2000, 12'h0, cms_pkg::CMD_CALL});
    chk(cms_pkg::OFF_PC, 32'hFFFF, 32'h2000);
    chk(cms_pkg::OFF_SP, 32'hFF, 32'hFD);
    wr(cms_pkg::OFF_RPS, 32'h1);
    wr(cms_pkg::OFF_CMD, {28'h0, cms_pkg::CMD_SET_DIRECT_PAGE_FLAG});
    wr(cms_pkg::OFF_DADDR, 32'hFF);
    chk(cms_pkg::OFF_DDATA, 32'hFF, 32'h04);
    wr(cms_pkg::OFF_DADDR, 32'hFE);
    chk(cms_pkg::OFF_DDATA, 32'hFF, 32'h56);
    wr(cms_pkg::OFF_CMD, {28'h0, cms_pkg::CMD_RET});
    chk(cms_pkg::OFF_PC, 32'hFFFF, 32'h0456);
    chk(cms_pkg::OFF_SP, 32'hFF, 32'hFF);
    wr(cms_pkg::OFF_CMD, {28'h0, cms_pkg::CMD_CLEAR_DIRECT_PAGE_FLAG});
  endtask
  task automatic t_page_call();
    wr(cms_pkg::OFF_PC, 32'h0300);
    wr(cms_pkg::OFF_CMD, {16'h0, 8'h35, 4'h0, cms_pkg::CMD_PAGE_CALL});
    chk(cms_pkg::OFF_PC, 32'hFFFF, 32'hFF35);
    chk(cms_pkg::OFF_SP, 32'hFF, 32'hFD);
    wr(cms_pkg::OFF_CMD, {28'h0, cms_pkg::CMD_RET});
    chk(cms_pkg::OFF_PC, 32'hFFFF, 32'h0300);
  endtask
  task automatic t_table_call();
    logic [3:0] k;
    logic [15:0] s;
    for (int n = 0; n < 16; n++) begin
      k = n[3:0];
      // slot 15 at FFC0, each lower index two bytes higher
      s = 16'hFFC0 + {11'h0, ~k, 1'b0};
      pb(s, {k, k});
      pb(s + 16'h1, 8'hA0);
      wr(cms_pkg::OFF_CMD, {24'h0, k, cms_pkg::CMD_TABLE_CALL});
      chk(cms_pkg::OFF_PC, 32'hFFFF, {16'h0, 8'hA0, k, k});
      wr(cms_pkg::OFF_CMD, {28'h0, cms_pkg::CMD_RET});
    end
  endtask
  task automatic t_int();
    pb(16'hFFFC, 8'h78);
    pb(16'hFFFD, 8'h56);
    wr(cms_pkg::OFF_PSW, 32'h05);
    wr(cms_pkg::OFF_PC, 32'h0111);
    wr(cms_pkg::OFF_CMD, {24'h0, 4'h1, cms_pkg::CMD_INT});
    chk(cms_pkg::OFF_PC, 32'hFFFF, 32'h5678);
    chk(cms_pkg::OFF_PSW, 32'hFF, 32'h01);
    chk(cms_pkg::OFF_SP, 32'hFF, 32'hFC);
    chk(cms_pkg::OFF_CMD, 32'hFF, {24'h0, 4'h1, cms_pkg::CMD_INT});
    wr(cms_pkg::OFF_PSW, 32'h00);
    wr(cms_pkg::OFF_CMD, {28'h0, cms_pkg::CMD_INTERRUPT_RETURN});
    chk(cms_pkg::OFF_PC, 32'hFFFF, 32'h0111);
    chk(cms_pkg::OFF_PSW, 32'hFF, 32'h05);
    chk(cms_pkg::OFF_SP, 32'hFF, 32'hFF);
  endtask
  task automatic t_page();
    wr(cms_pkg::OFF_RPS, 32'h0);
    wr(cms_pkg::OFF_CMD, {28'h0, cms_pkg::CMD_SET_DIRECT_PAGE_FLAG});
    wr(cms_pkg::OFF_DADDR, 32'h10);
    wr(cms_pkg::OFF_DDATA, 32'h3C);
    wr(cms_pkg::OFF_RPS, 32'h1);
    chk(cms_pkg::OFF_RPS, 32'hFFFFFFFF, 32'h1);
    wr(cms_pkg::OFF_CMD, {28'h0, cms_pkg::CMD_SET_DIRECT_PAGE_FLAG});
    wr(cms_pkg::OFF_DDATA, 32'hA5);
    chk(cms_pkg::OFF_STATUS, 32'h301, 32'h101);
    chk(cms_pkg::OFF_DDATA, 32'hFF, 32'hA5);
    wr(cms_pkg::OFF_CMD, {28'h0, cms_pkg::CMD_CLEAR_DIRECT_PAGE_FLAG});
    chk(cms_pkg::OFF_STATUS, 32'h301, 32'h001);
    chk(cms_pkg::OFF_DDATA, 32'hFF, 32'h3C);
    wr(cms_pkg::OFF_RPS, 32'h2);
    wr(cms_pkg::OFF_CMD, {28'h0, cms_pkg::CMD_SET_DIRECT_PAGE_FLAG});
    chk(cms_pkg::OFF_STATUS, 32'h301, 32'h200);
    chk(cms_pkg::OFF_DDATA, 32'hFF, 32'h0);
    wr(6'h3C, 32'h55);
    chk(6'h3C, 32'hFFFFFFFF, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_vector();
    t_fetch();
    t_call();
    t_page_call();
    t_table_call();
    t_int();
    t_page();
    summarize();
  end
  // about 750 transfer cycles expected; generous margin
  initial begin
    #2000000;
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
bind cms_top cms_top_sva u_sva (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire
